// ==== logic/asc_pkg.sv ====
// package of constants and types for the converter sequencer control block
package asc_pkg;
    // register byte addresses on the internal bus
    localparam logic [15:0] ASC_ADDR_RES_A_HI = 16'hFFE0;
    localparam logic [15:0] ASC_ADDR_RES_D_LO = 16'hFFE7;
    localparam logic [15:0] ASC_ADDR_CSR      = 16'hFFE8;
    localparam logic [7:0]  ASC_CSR_RESET     = 8'h00;
    // control/status field positions
    localparam int ASC_BIT_DONE  = 7;
    localparam int ASC_BIT_IRQEN = 6;
    localparam int ASC_BIT_RUN   = 5;
    localparam int ASC_BIT_SCAN  = 4;
    localparam int ASC_BIT_SPEED = 3;
    localparam int ASC_BIT_GROUP = 2;
    // result layout
    localparam int ASC_RES_W = 10;
    localparam logic [5:0] ASC_LO_PAD = 6'h00;
    // conversion durations in system states (one state = one clock)
    localparam int ASC_CONV_SLOW_STATES = 274;
    localparam int ASC_CONV_FAST_STATES = 138;
    localparam logic [8:0] ASC_CONV_SLOW_CYC = 9'(ASC_CONV_SLOW_STATES);
    localparam logic [8:0] ASC_CONV_FAST_CYC = 9'(ASC_CONV_FAST_STATES);
    // sequencer states, gray along idle -> start -> wait
    typedef enum logic [1:0] {
        ASC_IDLE  = 2'b00,
        ASC_START = 2'b01,
        ASC_WAIT  = 2'b11
    } asc_state_e;
endpackage

// ==== logic/asc_result_bank.sv ====
// four result registers with the shared lower-byte holding latch
`timescale 1ns/1ps
module asc_result_bank #(
    parameter int RES_W = asc_pkg::ASC_RES_W
) (
    input  wire logic             clk_in,      // system clock
    input  wire logic             reset_in,    // async reset, high
    input  wire logic             clear_in,    // standby clear
    input  wire logic             wr_en_in,    // store a new result
    input  wire logic [1:0]       wr_sel_in,   // register a..d
    input  wire logic [RES_W-1:0] wr_code_in,  // code to store
    input  wire logic             rd_hi_in,    // upper byte being read
    input  wire logic             rd_lo_in,    // lower byte being read
    input  wire logic [1:0]       rd_sel_in,   // register addressed
    output logic      [7:0]       rd_byte_out  // byte for the bus
);
    import asc_pkg::*;
    logic [RES_W-1:0] res_q [4];
    logic [RES_W-1:0] res_d [4];
    logic [1:0]       hold_q;
    logic [1:0]       hold_d;

    // ----------------------------------------
    // next values of results and latch
    // ----------------------------------------
    always_comb begin
        res_d  = res_q;
        hold_d = hold_q;
        if (clear_in) begin
            for (int i = 0; i < 4; i++) begin
                res_d[i] = '0;
            end
            hold_d = '0;
        end else begin
            if (wr_en_in) begin
                res_d[wr_sel_in] = wr_code_in;
            end
            if (rd_hi_in) begin
                hold_d = res_q[rd_sel_in][1:0];
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= '0;
            end
            hold_q <= '0;
        end else begin
            res_q  <= res_d;
            hold_q <= hold_d;
        end
    end

    // read mux: lower byte comes from the latch, never the live value
    always_comb begin
        rd_byte_out = 8'h00;
        if (rd_hi_in) begin
            rd_byte_out = res_q[rd_sel_in][9:2];
        end else if (rd_lo_in) begin
            rd_byte_out = {hold_q, ASC_LO_PAD};
        end
    end
endmodule

// ==== logic/asc_top.sv ====
// converter sequencer control: status register, sequencing, result bus reads
// Behaviour
// - control/status clears to zero on reset and standby
// - done flag sets per single conversion, or after a full scan pass
// - done flag clears by read-as-one then write zero; writing one ignored
// - transfer controller servicing the request clears the done flag
// - interrupt request equals irq enable and done flag
// - conversions run only while run bit is one
// - single mode: one conversion, then run bit self-clears
// - scan mode: channels cycle continuously until run written zero
// - bit 4 zero single mode, one scan mode
// - speed bit zero: 274 states, one: 138 states
// - single mode: group bit picks half, low bits pick input
// - result registers 16 bits, lower byte via holding latch
// - upper byte read copies lower byte into latch
// - lower byte read returns latch content
// - inputs n and n+4 share result register n
// - result 9..2 upper byte, 1..0 lower bits 7..6, rest zero
// - scan mode: group picks start, low bits give count minus one
`timescale 1ns/1ps
module asc_top (
    input  wire logic        clk_in,         // 200 MHz system clock
    input  wire logic        reset_in,       // async reset, high
    input  wire logic        standby_in,     // chip entering standby
    input  wire logic [15:0] bus_addr_in,    // internal bus byte address
    input  wire logic        bus_rd_in,      // read strobe, one cycle
    input  wire logic        bus_wr_in,      // write strobe, one cycle
    input  wire logic        bus_word_in,    // word access (even address)
    input  wire logic [15:0] bus_wdata_in,   // write data, byte in [7:0]
    input  wire logic        xfer_ack_in,    // transfer controller served request
    input  wire logic        core_done_in,   // analog core finished, one cycle
    input  wire logic [9:0]  core_code_in,   // code valid with done
    output logic      [15:0] bus_rdata_out,  // read data, next cycle
    output logic             irq_out,        // conversion_end_request
    output logic             core_start_out, // start pulse to analog core
    output logic      [2:0]  core_chan_out,  // analog input index
    output logic      [8:0]  core_cycles_out // conversion length for core
);
    import asc_pkg::*;

    logic [7:0]  csr_q;
    logic [7:0]  csr_d;
    logic        done_seen_q;
    logic        done_seen_d;
    asc_state_e  state_q;
    asc_state_e  state_d;
    logic [2:0]  chan_q;
    logic [2:0]  chan_d;
    logic        start_q;
    logic        start_d;
    logic [8:0]  cycles_q;
    logic [8:0]  cycles_d;
    logic        irq_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        store_en;
    logic        clear_all;
    logic        csr_rd;
    logic        csr_wr;
    logic        res_hit;
    logic        rd_hi;
    logic        rd_lo;
    logic [1:0]  rd_sel;
    logic [7:0]  res_byte;
    logic [7:0]  res_lo_live;
    logic [2:0]  last_chan;
    logic        run;
    logic        scan;

    assign clear_all = standby_in;
    assign run       = csr_q[ASC_BIT_RUN];
    assign scan      = csr_q[ASC_BIT_SCAN];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    always_comb begin
        csr_rd  = 1'b0;
        csr_wr  = 1'b0;
        res_hit = 1'b0;
        if (bus_addr_in == ASC_ADDR_CSR) begin
            csr_rd = bus_rd_in;
            csr_wr = bus_wr_in;
        end else if (bus_addr_in >= ASC_ADDR_RES_A_HI && bus_addr_in <= ASC_ADDR_RES_D_LO) begin
            res_hit = bus_rd_in;
        end
    end

    // a word read hits upper and lower in one access: latch fills, live low bits used
    assign rd_sel = bus_addr_in[2:1];
    assign rd_hi  = res_hit && !bus_addr_in[0];
    assign rd_lo  = res_hit && bus_addr_in[0] && !bus_word_in;

    // ----------------------------------------
    // control/status register
    // ----------------------------------------
    always_comb begin
        csr_d       = csr_q;
        done_seen_d = done_seen_q;
        if (csr_rd && csr_q[ASC_BIT_DONE]) begin
            done_seen_d = 1'b1;
        end
        if (csr_wr) begin
            csr_d[6:0] = bus_wdata_in[6:0];
            // zero clears only after a read saw it set; a one is ignored
            if (!bus_wdata_in[ASC_BIT_DONE] && done_seen_q) begin
                csr_d[ASC_BIT_DONE] = 1'b0;
                done_seen_d         = 1'b0;
            end
        end
        if (xfer_ack_in) begin
            csr_d[ASC_BIT_DONE] = 1'b0;
            done_seen_d         = 1'b0;
        end
        // single-mode completion stops the run bit, unless software rewrites it
        if (store_en && !scan && !(csr_wr && bus_wdata_in[ASC_BIT_RUN])) begin
            csr_d[ASC_BIT_RUN] = 1'b0;
        end
        // hardware set wins over a write or transfer-ack clear in the same cycle; standby clear still wins over it
        if (store_en && (!scan || chan_q == last_chan)) begin
            csr_d[ASC_BIT_DONE] = 1'b1;
        end
        if (clear_all) begin
            csr_d       = ASC_CSR_RESET;
            done_seen_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            csr_q       <= ASC_CSR_RESET;
            done_seen_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            csr_q       <= csr_d;
            done_seen_q <= done_seen_d;
            irq_q       <= csr_d[ASC_BIT_IRQEN] & csr_d[ASC_BIT_DONE];
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // scan end is group start plus count minus one; single uses the index itself
    assign last_chan = {csr_q[ASC_BIT_GROUP], csr_q[1:0]};
    assign store_en  = (state_q == ASC_WAIT) && core_done_in && run;

    always_comb begin
        state_d  = state_q;
        chan_d   = chan_q;
        start_d  = 1'b0;
        cycles_d = cycles_q;
        case (state_q)
            ASC_IDLE: begin
                if (run) begin
                    // single picks one input, scan starts at the group base
                    chan_d   = scan ? {csr_q[ASC_BIT_GROUP], 2'b00}
                                    : {csr_q[ASC_BIT_GROUP], csr_q[1:0]};
                    cycles_d = csr_q[ASC_BIT_SPEED] ? ASC_CONV_FAST_CYC
                                                    : ASC_CONV_SLOW_CYC;
                    state_d  = ASC_START;
                end
            end
            ASC_START: begin
                start_d = run;
                state_d = run ? ASC_WAIT : ASC_IDLE;
            end
            ASC_WAIT: begin
                if (!run) begin
                    state_d = ASC_IDLE;
                end else if (core_done_in) begin
                    if (scan) begin
                        // wrap to the group base after the last input
                        chan_d  = (chan_q == last_chan) ? {csr_q[ASC_BIT_GROUP], 2'b00}
                                                        : chan_q + 3'd1;
                        state_d = ASC_START;
                    end else begin
                        state_d = ASC_IDLE;
                    end
                end
            end
            default: state_d = ASC_IDLE;
        endcase
        if (clear_all) begin
            state_d = ASC_IDLE;
            start_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q  <= ASC_IDLE;
            chan_q   <= 3'd0;
            start_q  <= 1'b0;
            cycles_q <= ASC_CONV_SLOW_CYC;
        end else begin
            state_q  <= state_d;
            chan_q   <= chan_d;
            start_q  <= start_d;
            cycles_q <= cycles_d;
        end
    end

    // ----------------------------------------
    // result bank and read data
    // ----------------------------------------
    asc_result_bank #(
        .RES_W (ASC_RES_W)
    ) u_bank (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .clear_in    (clear_all),
        .wr_en_in    (store_en),
        .wr_sel_in   (chan_q[1:0]),
        .wr_code_in  (core_code_in),
        .rd_hi_in    (rd_hi),
        .rd_lo_in    (rd_lo),
        .rd_sel_in   (rd_sel),
        .rd_byte_out (res_byte)
    );

    // read data registered; word read returns upper:lower in one access
    always_comb begin
        rdata_d = 16'h0000;
        if (csr_rd) begin
            rdata_d = {8'h00, csr_q};
        end else if (rd_hi && bus_word_in) begin
            rdata_d = {res_byte, 8'h00} | {8'h00, res_lo_live};
        end else if (res_hit) begin
            rdata_d = {8'h00, res_byte};
        end
    end

    assign res_lo_live = {u_bank.res_q[rd_sel][1:0], ASC_LO_PAD};

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata_out   = rdata_q;
    assign irq_out         = irq_q;
    assign core_start_out  = start_q;
    assign core_chan_out   = chan_q;
    assign core_cycles_out = cycles_q;
endmodule

// ==== tb/asc_core_model.sv ====
// behavioural analog core that answers each start with one done pulse
`timescale 1ns/1ps
module asc_core_model (
    input  wire logic       clk_in,   // system clock
    input  wire logic       start_in, // start pulse
    input  wire logic [7:0] lat_in,   // answer delay
    output logic            done_out, // one-cycle done
    output logic      [9:0] code_out  // code, valid with done
);
    int cnt  = 0;
    int seed = 5;
    initial begin
        done_out = 1'b0;
        code_out = 10'h000;
    end
    // code toggles between answers so a stale capture cannot pass
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        code_out <= ~code_out;
        if (start_in) begin
            cnt <= lat_in + 1;
        end else if (cnt == 1) begin
            done_out <= 1'b1;
            code_out <= 10'($random(seed));
            cnt      <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ==== tb/asc_top_monitor.sv ====
// port checker for the converter sequencer control block
`timescale 1ns/1ps
module asc_top_monitor
    import asc_pkg::*;
(
    input wire logic        clk_in,          // clock
    input wire logic        reset_in,        // reset
    input wire logic        standby_in,      // standby
    input wire logic [15:0] bus_addr_in,     // address
    input wire logic        bus_rd_in,       // read
    input wire logic        bus_wr_in,       // write
    input wire logic        bus_word_in,     // word
    input wire logic        xfer_ack_in,     // ack
    input wire logic        core_done_in,    // done
    input wire logic [15:0] bus_rdata_out,   // read data
    input wire logic        irq_out,         // request
    input wire logic        core_start_out,  // start
    input wire logic [8:0]  core_cycles_out  // length
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_res_rd;
        bus_rd_in && bus_addr_in[15:3] == ASC_ADDR_RES_A_HI[15:3];
    endsequence
    sequence s_ack_quiet;
        xfer_ack_in && !core_done_in ##1 !core_done_in;
    endsequence
    a_start_one_cycle: assert property (core_start_out |=> !core_start_out)
        else $error("start pulse longer than one cycle");
    a_cycles_legal: assert property (core_cycles_out == ASC_CONV_SLOW_CYC
        || core_cycles_out == ASC_CONV_FAST_CYC) else $error("bad conversion length");
    a_rdata_idle: assert property (!bus_rd_in |=> bus_rdata_out == 16'h0000)
        else $error("read data without a read");
    a_lo_byte_pad: assert property (s_res_rd ##0 (bus_addr_in[0] && !bus_word_in)
        |=> bus_rdata_out[5:0] == ASC_LO_PAD && bus_rdata_out[15:8] == 8'h00)
        else $error("lower byte pad bits set");
    a_word_pad: assert property (s_res_rd ##0 (!bus_addr_in[0] && bus_word_in)
        |=> bus_rdata_out[5:0] == ASC_LO_PAD) else $error("word pad bits set");
    a_irq_ack_drop: assert property (s_ack_quiet |=> !irq_out)
        else $error("request stayed after transfer ack");
    a_irq_rise_cause: assert property ($rose(irq_out)
        |-> $past(core_done_in, 1) || $past(bus_wr_in, 1)) else $error("request from nowhere");
    a_start_cause: assert property ($rose(core_start_out)
        |-> $past(bus_wr_in, 3) || $past(core_done_in, 2)) else $error("start from nowhere");
    a_standby_quiet: assert property (standby_in ##1 standby_in
        |=> !irq_out && !core_start_out) else $error("activity in standby");
endmodule
bind asc_top asc_top_monitor u_mon (.clk_in, .reset_in, .standby_in, .bus_addr_in,
    .bus_rd_in, .bus_wr_in, .bus_word_in, .xfer_ack_in, .core_done_in, .bus_rdata_out,
    .irq_out, .core_start_out, .core_cycles_out);

// ==== tb/asc_top_tb.sv ====
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module asc_top_tb;
    import asc_pkg::*;
    logic        clk_in = 1'b0, reset_in = 1'b1, standby_in = 1'b0, xfer_ack_in = 1'b0;
    logic        bus_rd_in = 1'b0, bus_wr_in = 1'b0, bus_word_in = 1'b0;
    logic [15:0] bus_addr_in = 16'h0000, bus_wdata_in = 16'h0000, bus_rdata_out;
    logic        core_done_in, irq_out, core_start_out;
    logic [9:0]  core_code_in;
    logic [2:0]  core_chan_out;
    logic [8:0]  core_cycles_out;
    logic [7:0]  lat = 8'h04;
    int          bad_count = 0, checks = 0, seed = 22, exp_cyc = 274, cur = 0;
    int          exp_res [4] = '{0, 0, 0, 0};
    int          chq [$];
    bit          running = 1'b0;
    always #2.5 clk_in = ~clk_in;
    asc_top dut (.clk_in, .reset_in, .standby_in, .bus_addr_in, .bus_rd_in, .bus_wr_in,
        .bus_word_in, .bus_wdata_in, .xfer_ack_in, .core_done_in, .core_code_in,
        .bus_rdata_out, .irq_out, .core_start_out, .core_chan_out, .core_cycles_out);
    asc_core_model core (.clk_in, .start_in(core_start_out), .lat_in(lat),
        .done_out(core_done_in), .code_out(core_code_in));
    task automatic chk(input logic [15:0] got, input int exp);
        checks++;
        if (got !== 16'(exp)) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, 16'(exp));
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one-cycle bus strobes launched on the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        bus_addr_in = a;
        bus_wdata_in = {8'h00, d};
        bus_wr_in = 1'b1;
        @(negedge clk_in);
        bus_wr_in = 1'b0;
    endtask
    task automatic rdb(input logic [15:0] a, input logic w, output logic [15:0] q);
        @(negedge clk_in);
        bus_addr_in = a;
        bus_word_in = w;
        bus_rd_in = 1'b1;
        @(negedge clk_in);
        bus_rd_in = 1'b0;
        bus_word_in = 1'b0;
        q = bus_rdata_out;
    endtask
    // upper byte, then another register's lower byte, which shows the shared latch
    task automatic res_chk(input int r);
        logic [15:0] q;
        rdb(ASC_ADDR_RES_A_HI + 16'(2 * r), 1'b0, q);
        chk(q, exp_res[r] >> 2);
        rdb(ASC_ADDR_RES_A_HI + 16'(2 * ((r + 1) % 4) + 1), 1'b0, q);
        chk(q, (exp_res[r] & 3) << 6);
        rdb(ASC_ADDR_RES_A_HI + 16'(2 * r), 1'b1, q);
        chk(q, ((exp_res[r] >> 2) << 8) | ((exp_res[r] & 3) << 6));
    endtask
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq_out !== v && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        chk(16'(irq_out), v);
    endtask
    // model of channel order, length and stored codes
    always @(posedge clk_in) begin
        if (core_start_out === 1'b1) begin
            cur = chq.size() ? chq.pop_front() : 99;
            chk(16'(core_chan_out), cur);
            chk(16'(core_cycles_out), exp_cyc);
        end
        if (core_done_in === 1'b1 && running) exp_res[cur % 4] = core_code_in;
    end
    initial begin
        #400000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        logic [15:0] q;
        int c, s, g, n;
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        rdb(ASC_ADDR_CSR, 1'b0, q);
        chk(q, ASC_CSR_RESET);
        wr(ASC_ADDR_RES_A_HI, 8'hFF);
        rdb(16'hFFF0, 1'b0, q);
        chk(q, 0);
        for (c = 0; c < 4; c++) res_chk(c);
        for (c = 0; c < 8; c++) begin
            s = c & 1;
            exp_cyc = s ? ASC_CONV_FAST_STATES : ASC_CONV_SLOW_STATES;
            lat = 8'($random(seed) & 63);
            chq.push_back(c);
            running = 1'b1;
            wr(ASC_ADDR_CSR, 8'(8'h60 | (s << 3) | c));
            wait_irq(1'b1);
            rdb(ASC_ADDR_CSR, 1'b0, q);
            chk(q, 8'hC0 | (s << 3) | c);
            wr(ASC_ADDR_CSR, 8'(8'h80 | c));
            wait_irq(1'b0);
            rdb(ASC_ADDR_CSR, 1'b0, q);
            chk(q, 8'h80 | c);
            wr(ASC_ADDR_CSR, 8'(c));
            rdb(ASC_ADDR_CSR, 1'b0, q);
            chk(q, c);
            chk(16'(chq.size()), 0);
            res_chk(c % 4);
        end
        for (s = 0; s < 2; s++) begin
            g = $random(seed) & 4;
            n = s ? 3 : ($random(seed) & 3);
            exp_cyc = s ? ASC_CONV_FAST_STATES : ASC_CONV_SLOW_STATES;
            lat = 8'(20 + ($random(seed) & 31));
            for (int p = 0; p < 3; p++) for (int j = 0; j <= n; j++) chq.push_back(g + j);
            running = 1'b1;
            wr(ASC_ADDR_CSR, 8'(8'h70 | (s << 3) | g | n));
            wait_irq(1'b1);
            rdb(ASC_ADDR_CSR, 1'b0, q);
            chk(q, 8'hF0 | (s << 3) | g | n);
            @(negedge clk_in);
            xfer_ack_in = 1'b1;
            @(negedge clk_in);
            xfer_ack_in = 1'b0;
            wait_irq(1'b0);
            wait_irq(1'b1);
            wr(ASC_ADDR_CSR, 8'(8'h80 | (s << 3) | g | n));
            running = 1'b0;
            chq.delete();
            repeat (80) @(negedge clk_in);
            rdb(ASC_ADDR_CSR, 1'b0, q);
            chk(q, 8'h80 | (s << 3) | g | n);
            for (int j = 0; j <= n; j++) res_chk(j);
        end
        @(negedge clk_in);
        standby_in = 1'b1;
        repeat (2) @(negedge clk_in);
        standby_in = 1'b0;
        exp_res = '{0, 0, 0, 0};
        rdb(ASC_ADDR_CSR, 1'b0, q);
        chk(q, ASC_CSR_RESET);
        for (c = 0; c < 4; c++) res_chk(c);
        tally_and_finish;
    end
endmodule
